/* File: haptic_tuning_defines.svh */
// register offsets, reset values and field widths of the haptic waveform tuning bank
// assumes a same-clock register port in front (serial front end lives elsewhere)
`ifndef HAPTIC_TUNING_DEFINES_SVH
`define HAPTIC_TUNING_DEFINES_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFS_NEG_SUSTAIN_OFFSET   8'h1C
`define OFS_BRAKE_SEGMENT_OFFSET 8'h1D
`define OFS_FULL_SCALE_REF       8'h1F
`define OFS_PEAK_DRIVE_LIMIT     8'h20
`define OFS_LOSS_COMPENSATION    8'h21
`define OFS_FEEDBACK_GAIN_BASIS  8'h22

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_NEG_SUSTAIN_OFFSET   8'h00
`define RST_BRAKE_SEGMENT_OFFSET 8'h00
`define RST_FULL_SCALE_REF       8'h3F
`define RST_PEAK_DRIVE_LIMIT     8'h89
`define RST_LOSS_COMPENSATION    8'h0D
`define RST_FEEDBACK_GAIN_BASIS  8'h6D

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define REG_WIDTH                8
`define SEG_LEN_WIDTH            10
`define STEP_PERIOD_WIDTH        8

`endif

/* File: haptic_tuning_pkg.sv */
// types shared by the haptic waveform tuning bank
// assumes haptic_tuning_defines.svh is on the include path
`include "haptic_tuning_defines.svh"

package haptic_tuning_pkg;

    typedef logic [`REG_WIDTH-1:0]         reg_t;
    typedef logic signed [`REG_WIDTH-1:0]  sample_t;
    typedef logic [`SEG_LEN_WIDTH-1:0]     seg_len_t;

    // segment kinds found in a library waveform, one-hot
    typedef enum logic [3:0] {
        SEG_OVERDRIVE    = 4'b0001,
        SEG_POS_SUSTAIN  = 4'b0010,
        SEG_NEG_SUSTAIN  = 4'b0100,
        SEG_BRAKE        = 4'b1000
    } seg_kind_e;

endpackage : haptic_tuning_pkg

/* File: segment_time_adjust.sv */
// adds a signed step offset to a segment length, saturating at zero and at full scale
// assumes offset and length come from flip-flops on the same clock
`timescale 1ns/1ps

module segment_time_adjust #(
    parameter int LEN_W = 10,
    parameter int OFS_W = 8
) (
    input  wire logic [LEN_W-1:0]        i_base_len,
    input  wire logic signed [OFS_W-1:0] i_offset,
    input  wire logic                    i_apply,
    output logic      [LEN_W-1:0]        o_adj_len
);

    logic signed [LEN_W+1:0] sum;

    always_comb
    begin
        sum = $signed({2'b00, i_base_len}) + (i_apply ? LEN_W'(0) + (LEN_W+2)'(i_offset) : (LEN_W+2)'(0));
        if (sum < 0)
        begin
            o_adj_len = '0;
        end
        else if (sum[LEN_W])
        begin
            o_adj_len = '1;
        end
        else
        begin
            o_adj_len = sum[LEN_W-1:0];
        end
    end

endmodule : segment_time_adjust

/* File: haptic_waveform_tuning_regs.sv */
// tuning register bank of the haptic playback engine, with segment timing and drive clamp
// assumes a same-clock register port (address, write strobe, data) from the serial front end,
// and a playback engine that presents one waveform segment at a time with the waveform extremes
`timescale 1ns/1ps
`include "haptic_tuning_defines.svh"

module haptic_waveform_tuning_regs (
    input  wire logic                          i_clock,
    input  wire logic                          i_sys_rst,
    // register port
    input  wire logic [7:0]                    i_reg_addr,
    input  wire logic                          i_reg_wr,
    input  wire logic                          i_reg_rd,
    input  wire haptic_tuning_pkg::reg_t       i_reg_wdata,
    output haptic_tuning_pkg::reg_t            o_reg_rdata,
    output logic                               o_reg_hit,
    // playback engine: current segment
    input  wire logic                          i_seg_valid,
    input  wire haptic_tuning_pkg::sample_t    i_seg_value,
    input  wire haptic_tuning_pkg::sample_t    i_wave_max,
    input  wire haptic_tuning_pkg::sample_t    i_wave_min,
    input  wire haptic_tuning_pkg::seg_len_t   i_seg_len,
    input  wire logic [`STEP_PERIOD_WIDTH-1:0] i_step_period,
    input  wire logic                          i_closed_loop,
    output haptic_tuning_pkg::seg_kind_e       o_seg_kind,
    output haptic_tuning_pkg::seg_len_t        o_seg_len,
    output logic [`SEG_LEN_WIDTH+`STEP_PERIOD_WIDTH-1:0] o_seg_time,
    output logic                               o_seg_done,
    // closed-loop drive
    input  wire haptic_tuning_pkg::reg_t       i_drive_request,
    input  wire logic                          i_auto_od_brake,
    output haptic_tuning_pkg::reg_t            o_drive_level,
    output haptic_tuning_pkg::reg_t            o_full_scale_ref,
    output haptic_tuning_pkg::reg_t            o_feedback_gain_basis,
    output haptic_tuning_pkg::reg_t            o_loss_compensation,
    // calibration engine
    input  wire logic                          i_cal_done,
    input  wire haptic_tuning_pkg::reg_t       i_cal_loss_comp,
    input  wire haptic_tuning_pkg::reg_t       i_cal_gain_basis
);

    import haptic_tuning_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg_t       neg_sustain_time_offset;
    reg_t       brake_time_offset;
    reg_t       full_scale_reference_level;
    reg_t       closed_loop_peak_clamp;
    reg_t       loss_compensation_result;
    reg_t       feedback_gain_basis;
    logic       wr_neg;
    logic       wr_brk;
    logic       wr_fsr;
    logic       wr_clamp;
    logic       wr_comp;
    logic       wr_gain;

    assign wr_neg   = i_reg_wr && (i_reg_addr == `OFS_NEG_SUSTAIN_OFFSET);
    assign wr_brk   = i_reg_wr && (i_reg_addr == `OFS_BRAKE_SEGMENT_OFFSET);
    assign wr_fsr   = i_reg_wr && (i_reg_addr == `OFS_FULL_SCALE_REF);
    assign wr_clamp = i_reg_wr && (i_reg_addr == `OFS_PEAK_DRIVE_LIMIT);
    assign wr_comp  = i_reg_wr && (i_reg_addr == `OFS_LOSS_COMPENSATION);
    assign wr_gain  = i_reg_wr && (i_reg_addr == `OFS_FEEDBACK_GAIN_BASIS);

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            neg_sustain_time_offset    <= `RST_NEG_SUSTAIN_OFFSET;
            brake_time_offset          <= `RST_BRAKE_SEGMENT_OFFSET;
            full_scale_reference_level <= `RST_FULL_SCALE_REF;
            closed_loop_peak_clamp     <= `RST_PEAK_DRIVE_LIMIT;
        end
        else
        begin
            if (wr_neg)
            begin
                neg_sustain_time_offset <= i_reg_wdata;
            end
            if (wr_brk)
            begin
                brake_time_offset <= i_reg_wdata;
            end
            if (wr_fsr)
            begin
                full_scale_reference_level <= i_reg_wdata;
            end
            if (wr_clamp)
            begin
                closed_loop_peak_clamp <= i_reg_wdata;
            end
        end
    end

    // calibration results; a finishing calibration wins over a host write in the same cycle
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            loss_compensation_result <= `RST_LOSS_COMPENSATION;
            feedback_gain_basis      <= `RST_FEEDBACK_GAIN_BASIS;
        end
        else if (i_cal_done)
        begin
            loss_compensation_result <= i_cal_loss_comp;
            feedback_gain_basis      <= i_cal_gain_basis;
        end
        else
        begin
            if (wr_comp)
            begin
                loss_compensation_result <= i_reg_wdata;
            end
            if (wr_gain)
            begin
                feedback_gain_basis <= i_reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    reg_t next_rdata;
    logic next_hit;

    always_comb
    begin
        next_hit = 1'b1;
        case (i_reg_addr)
            `OFS_NEG_SUSTAIN_OFFSET:   next_rdata = neg_sustain_time_offset;
            `OFS_BRAKE_SEGMENT_OFFSET: next_rdata = brake_time_offset;
            `OFS_FULL_SCALE_REF:       next_rdata = full_scale_reference_level;
            `OFS_PEAK_DRIVE_LIMIT:     next_rdata = closed_loop_peak_clamp;
            `OFS_LOSS_COMPENSATION:    next_rdata = loss_compensation_result;
            `OFS_FEEDBACK_GAIN_BASIS:  next_rdata = feedback_gain_basis;
            default:
            begin
                next_rdata = '0;
                next_hit   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_reg_rdata <= '0;
            o_reg_hit   <= 1'b0;
        end
        else if (i_reg_rd)
        begin
            o_reg_rdata <= next_rdata;
            o_reg_hit   <= next_hit;
        end
    end

    // ----------------------------------------------------------------
    // segment classification
    // ----------------------------------------------------------------
    seg_kind_e next_kind;
    logic      apply_offset;
    reg_t      seg_offset;
    seg_len_t  adj_len;

    always_comb
    begin
        if ((i_seg_value == i_wave_min) && (i_seg_value < 0))
        begin
            next_kind = SEG_BRAKE;
        end
        else if ((i_seg_value == i_wave_max) && (i_seg_value > 0))
        begin
            next_kind = SEG_OVERDRIVE;
        end
        else if (i_seg_value < 0)
        begin
            next_kind = SEG_NEG_SUSTAIN;
        end
        else
        begin
            next_kind = SEG_POS_SUSTAIN;
        end
    end

    always_comb
    begin
        case (next_kind)
            SEG_NEG_SUSTAIN:
            begin
                seg_offset   = neg_sustain_time_offset;
                apply_offset = 1'b1;
            end
            SEG_BRAKE:
            begin
                seg_offset   = brake_time_offset;
                apply_offset = !i_closed_loop;
            end
            default:
            begin
                // overdrive and positive sustain offsets are handled elsewhere
                seg_offset   = '0;
                apply_offset = 1'b0;
            end
        endcase
    end

    segment_time_adjust #(
        .LEN_W (`SEG_LEN_WIDTH),
        .OFS_W (`REG_WIDTH)
    ) u_adjust (
        .i_base_len (i_seg_len),
        .i_offset   ($signed(seg_offset)),
        .i_apply    (apply_offset),
        .o_adj_len  (adj_len)
    );

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_seg_kind <= SEG_POS_SUSTAIN;
            o_seg_len  <= '0;
            o_seg_time <= '0;
            o_seg_done <= 1'b0;
        end
        else
        begin
            o_seg_done <= i_seg_valid;
            if (i_seg_valid)
            begin
                o_seg_kind <= next_kind;
                o_seg_len  <= adj_len;
                o_seg_time <= adj_len * i_step_period;
            end
        end
    end

    // ----------------------------------------------------------------
    // closed-loop drive limit
    // ----------------------------------------------------------------
    reg_t next_drive;

    always_comb
    begin
        if (!i_closed_loop)
        begin
            next_drive = i_drive_request;
        end
        else if (i_auto_od_brake)
        begin
            next_drive = (i_drive_request > closed_loop_peak_clamp) ? closed_loop_peak_clamp : i_drive_request;
        end
        else
        begin
            next_drive = (i_drive_request > full_scale_reference_level) ? full_scale_reference_level
                                                                        : i_drive_request;
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_drive_level <= '0;
        end
        else
        begin
            o_drive_level <= next_drive;
        end
    end

    assign o_full_scale_ref      = full_scale_reference_level;
    assign o_feedback_gain_basis = feedback_gain_basis;
    assign o_loss_compensation   = loss_compensation_result;

endmodule : haptic_waveform_tuning_regs

/* File: haptic_tuning_monitor.sv */
// port assertions for the haptic tuning bank
// assumes one clock and the async active-high reset
`timescale 1ns/1ps
`include "haptic_tuning_defines.svh"
module haptic_tuning_monitor (
    input wire logic                               i_clock,
    input wire logic                               i_sys_rst,
    input wire logic [7:0]                         i_reg_addr,
    input wire logic                               i_reg_wr,
    input wire haptic_tuning_pkg::reg_t            i_reg_wdata,
    input wire logic                               i_seg_valid,
    input wire haptic_tuning_pkg::sample_t         i_seg_value,
    input wire haptic_tuning_pkg::sample_t         i_wave_min,
    input wire haptic_tuning_pkg::seg_len_t        i_seg_len,
    input wire logic [`STEP_PERIOD_WIDTH-1:0]      i_step_period,
    input wire logic                               i_closed_loop,
    input wire haptic_tuning_pkg::seg_kind_e       o_seg_kind,
    input wire haptic_tuning_pkg::seg_len_t        o_seg_len,
    input wire logic [`SEG_LEN_WIDTH+`STEP_PERIOD_WIDTH-1:0] o_seg_time,
    input wire logic                               o_seg_done,
    input wire haptic_tuning_pkg::reg_t            i_drive_request,
    input wire logic                               i_auto_od_brake,
    input wire haptic_tuning_pkg::reg_t            o_drive_level,
    input wire haptic_tuning_pkg::reg_t            o_full_scale_ref,
    input wire haptic_tuning_pkg::reg_t            o_feedback_gain_basis,
    input wire haptic_tuning_pkg::reg_t            o_loss_compensation,
    input wire logic                               i_cal_done,
    input wire haptic_tuning_pkg::reg_t            i_cal_loss_comp,
    input wire haptic_tuning_pkg::reg_t            i_cal_gain_basis
);
    import haptic_tuning_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // the clamp register is not a port: rebuild it from host writes seen at the register port
    reg_t clamp_shadow;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            clamp_shadow <= `RST_PEAK_DRIVE_LIMIT;
        end
        else if (i_reg_wr && (i_reg_addr == `OFS_PEAK_DRIVE_LIMIT))
        begin
            clamp_shadow <= i_reg_wdata;
        end
    end
    // most negative sample of the waveform
    sequence s_brake_seg;
        i_seg_valid && i_seg_value == i_wave_min && i_seg_value < 0;
    endsequence
    sequence s_closed_brake;
        s_brake_seg ##0 i_closed_loop;
    endsequence
    chk_seg_done_pulse : assert property (o_seg_done == $past(i_seg_valid))
        else $error("segment done not one cycle after valid");
    chk_brake_kind : assert property (s_brake_seg |=> o_seg_kind == SEG_BRAKE)
        else $error("brake segment misclassified");
    chk_neg_sustain_kind : assert property (i_seg_valid && i_seg_value < 0 && i_seg_value != i_wave_min
        |=> o_seg_kind == SEG_NEG_SUSTAIN) else $error("negative sustain misclassified");
    chk_closed_brake_len : assert property (s_closed_brake |=> o_seg_len == $past(i_seg_len))
        else $error("brake offset used in closed loop");
    chk_seg_time : assert property (o_seg_done |-> o_seg_time == o_seg_len * $past(i_step_period))
        else $error("segment time not length times step");
    chk_full_scale_cap : assert property (i_closed_loop && !i_auto_od_brake |=>
        (o_drive_level == $past(i_drive_request) || o_drive_level == $past(o_full_scale_ref))
        && o_drive_level <= $past(o_full_scale_ref)) else $error("drive above full scale");
    chk_auto_window_cap : assert property (i_closed_loop && i_auto_od_brake |=>
        o_drive_level == (($past(i_drive_request) > $past(clamp_shadow)) ? $past(clamp_shadow)
                                                                          : $past(i_drive_request)))
        else $error("drive not limited by peak clamp in window");
    chk_cal_loss_load : assert property (i_cal_done |=> o_loss_compensation == $past(i_cal_loss_comp))
        else $error("loss compensation not loaded");
    chk_cal_gain_load : assert property (i_cal_done |=> o_feedback_gain_basis == $past(i_cal_gain_basis))
        else $error("gain basis not loaded");
endmodule : haptic_tuning_monitor
bind haptic_waveform_tuning_regs haptic_tuning_monitor i_haptic_tuning_monitor (.*);

/* File: cal_engine_model.sv */
// calibration engine stand-in: measures a fixed impedance, returns results
// assumes the bank samples results on the rising edge with the done pulse
`timescale 1ns/1ps
module cal_engine_model #(
    parameter int         CAL_CYCLES = 12,
    parameter logic [7:0] IMPEDANCE  = 8'h28
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_start,
    input  wire haptic_tuning_pkg::reg_t  i_full_scale_ref,
    output logic                          o_done,
    output haptic_tuning_pkg::reg_t       o_loss_comp,
    output haptic_tuning_pkg::reg_t       o_gain_basis
);
    import haptic_tuning_pkg::*;
    int count;
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            count <= 0;
        else if (i_start)
            count <= CAL_CYCLES;
        else if (count > 0)
            count <= count - 1;
    end
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_done       <= 1'b0;
            o_loss_comp  <= 8'h00;
            o_gain_basis <= 8'h00;
        end
        else
        begin
            o_done       <= (count == 1);
            // results are junk outside the done pulse
            o_loss_comp  <= (count == 1) ? IMPEDANCE >> 2 : ~o_loss_comp;
            o_gain_basis <= (count == 1) ? i_full_scale_ref + IMPEDANCE : ~o_gain_basis;
        end
    end
endmodule : cal_engine_model

/* File: haptic_waveform_tuning_regs_test.sv */
// self-checking bench for the haptic tuning bank
// assumes inputs change at the falling edge, design samples on the rising edge
`timescale 1ns/1ps
module haptic_waveform_tuning_regs_test;
    import haptic_tuning_pkg::*;
    logic       clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, seg_valid = 0, closed_loop = 0;
    logic       auto_win = 0, hit, seg_done, cal_start = 0, cal_done;
    logic [7:0] reg_addr = 8'h00, step_period = 8'h04;
    reg_t       wdata = 8'h00, drive_req = 8'h00, rdata, drive_level, fs_ref, gain_basis, loss_comp;
    reg_t       cal_loss, cal_gain;
    sample_t    seg_value = 8'h00, wave_max = 8'h07, wave_min = 8'hFB;
    seg_len_t   seg_len = 10'h000, out_len;
    seg_kind_e  seg_kind;
    logic [17:0] seg_time;
    int         num_errors = 0, checked = 0;
    logic [7:0] addrs [6] = '{8'h1C, 8'h1D, 8'h1F, 8'h20, 8'h21, 8'h22};
    reg_t       resets [6] = '{8'h00, 8'h00, 8'h3F, 8'h89, 8'h0D, 8'h6D};
    always #25 clock = ~clock;
    haptic_waveform_tuning_regs i_haptic_waveform_tuning_regs (.i_clock(clock), .i_sys_rst(sys_rst),
        .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .o_reg_hit(hit), .i_seg_valid(seg_valid), .i_seg_value(seg_value),
        .i_wave_max(wave_max), .i_wave_min(wave_min), .i_seg_len(seg_len), .i_step_period(step_period),
        .i_closed_loop(closed_loop), .o_seg_kind(seg_kind), .o_seg_len(out_len), .o_seg_time(seg_time),
        .o_seg_done(seg_done), .i_drive_request(drive_req), .i_auto_od_brake(auto_win),
        .o_drive_level(drive_level), .o_full_scale_ref(fs_ref), .o_feedback_gain_basis(gain_basis),
        .o_loss_compensation(loss_comp), .i_cal_done(cal_done), .i_cal_loss_comp(cal_loss),
        .i_cal_gain_basis(cal_gain));
    cal_engine_model i_cal_engine_model (.i_clock(clock), .i_sys_rst(sys_rst), .i_start(cal_start),
        .i_full_scale_ref(fs_ref), .o_done(cal_done), .o_loss_comp(cal_loss), .o_gain_basis(cal_gain));
    task cmp_reg(input string name, input reg_t exp, input reg_t got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_reg
    task reg_write(input logic [7:0] a, input reg_t d);
        reg_addr = a;
        wdata = d;
        reg_wr = 1;
        @(negedge clock);
        reg_wr = 0;
        @(negedge clock);
    endtask : reg_write
    task reg_read(input logic [7:0] a, input reg_t exp, input logic exp_hit);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clock);
        reg_rd = 0;
        cmp_reg("rdata", exp, rdata);
        cmp_reg("hit", {7'h00, exp_hit}, {7'h00, hit});
        @(negedge clock);
    endtask : reg_read
    task seg_run(input sample_t v, input logic cl, input seg_kind_e k, input seg_len_t len);
        seg_value = v;
        seg_len = 10'h00A;
        closed_loop = cl;
        seg_valid = 1;
        @(negedge clock);
        seg_valid = 0;
        cmp_reg("done", 8'h01, {7'h00, seg_done});
        cmp_reg("kind", {4'h0, k}, {4'h0, seg_kind});
        cmp_reg("len", len[7:0], out_len[7:0]);
        cmp_reg("time", 8'(len * step_period), seg_time[7:0]);
        @(negedge clock);
    endtask : seg_run
    task drive(input reg_t req, input logic cl, input logic aw, input reg_t exp);
        drive_req = req;
        closed_loop = cl;
        auto_win = aw;
        @(negedge clock);
        cmp_reg("drive", exp, drive_level);
    endtask : drive
    task test_done;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    // about 75 cycles of tests; the limit leaves ample margin
    initial
    begin
        #100us;
        num_errors++;
        test_done;
    end
    initial
    begin
        repeat (6) @(negedge clock);
        sys_rst = 0;
        foreach (addrs[i]) reg_read(addrs[i], resets[i], 1'b1);
        reg_read(8'h1E, 8'h00, 1'b0);
        reg_write(8'h1C, 8'hFE);
        reg_write(8'h1D, 8'h03);
        reg_read(8'h1C, 8'hFE, 1'b1);
        reg_read(8'h1D, 8'h03, 1'b1);
        seg_run(8'hFD, 1'b0, SEG_NEG_SUSTAIN, 10'h008);
        seg_run(8'hFB, 1'b0, SEG_BRAKE, 10'h00D);
        seg_run(8'hFB, 1'b1, SEG_BRAKE, 10'h00A);
        step_period = 8'h06;
        seg_run(8'h07, 1'b0, SEG_OVERDRIVE, 10'h00A);
        step_period = 8'h04;
        reg_write(8'h1C, 8'h80);
        seg_run(8'hFD, 1'b0, SEG_NEG_SUSTAIN, 10'h000);
        reg_write(8'h1F, 8'h30);
        reg_write(8'h20, 8'h50);
        reg_read(8'h1F, 8'h30, 1'b1);
        cmp_reg("fs_ref", 8'h30, fs_ref);
        drive(8'h40, 1'b1, 1'b0, 8'h30);
        drive(8'h60, 1'b1, 1'b1, 8'h50);
        drive(8'h40, 1'b1, 1'b1, 8'h40);
        drive(8'h90, 1'b0, 1'b0, 8'h90);
        reg_write(8'h21, 8'h33);
        reg_read(8'h21, 8'h33, 1'b1);
        cal_start = 1;
        @(negedge clock);
        cal_start = 0;
        for (int n = 0; n < 40 && cal_done !== 1'b1; n++) @(negedge clock);
        @(negedge clock);
        cmp_reg("loss", 8'h0A, loss_comp);
        cmp_reg("gain", 8'h58, gain_basis);
        reg_read(8'h21, 8'h0A, 1'b1);
        reg_read(8'h22, 8'h58, 1'b1);
        test_done;
    end
endmodule : haptic_waveform_tuning_regs_test
